// ---- common/halt_dbg_params.svh ----
// Offsets, field positions, key and reset values of the halting debug registers
`ifndef HALT_DBG_PARAMS_SVH
`define HALT_DBG_PARAMS_SVH
`define EVT_FLAG_ADDR      32'he000ed30
`define EVT_FLAG_ALIAS     32'he002ed30
`define HALT_REG_ADDR      32'he000edf0
`define HALT_REG_ALIAS     32'he002edf0
`define WRITE_KEY          16'ha05f
`define EVT_EXT_BIT        4
`define EVT_VECTOR_CATCH_FLAG_BIT     3
`define EVT_WATCH_BIT      2
`define EVT_BREAKPOINT_FLAG_BIT       1
`define EVT_HALT_BIT       0
`define ST_RESTART_BIT     26
`define ST_RESET_BIT       25
`define ST_RETIRE_BIT      24
`define ST_SDE_BIT         20
`define ST_LOCKUP_BIT      19
`define ST_SLEEP_BIT       18
`define ST_HALT_BIT        17
`define ST_REGRDY_BIT      16
`define C_SNAP_BIT         5
`define C_MASK_BIT         3
`define C_STEP_BIT         2
`define C_HALT_BIT         1
`define C_DBGEN_BIT        0
`define EVT_FLAGS_RST      5'h00
`endif

// ---- common/halt_dbg_pkg.sv ----
// Types shared by the halting debug control and status block
package halt_dbg_pkg;
	// One register access from the system bus side
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        word;
		logic        priv;
		logic        secure;
		logic        debugger;
	} reg_req_t;
	// Core state and event strobes seen by the block
	typedef struct packed {
		logic ext_req;
		logic vector_catch_flag;
		logic watch;
		logic breakpoint_flag;
		logic halt_step;
		logic restart_req;
		logic retire;
		logic in_debug;
		logic sleeping;
		logic locked_up;
		logic secure_state;
		logic sec_halt_allowed;
		logic halt_allowed;
		logic xfer_req;
		logic xfer_done;
	} core_evt_t;
	// Internal state of the block
	typedef struct packed {
		logic [4:0]  evt_flags;
		logic        restart_st;
		logic        reset_st;
		logic        retire_st;
		logic        sde_latch;
		logic        regrdy;
		logic        snap;
		logic        mask;
		logic        step;
		logic        halt;
		logic        dbgen;
		logic        catch_on_reset_enable;
		logic        in_debug;
		logic [31:0] rdata;
		logic        fault;
		logic        ack;
	} state_t;
endpackage

// ---- src/halting_debug_status_control.sv ----
// Halting debug event flags and halting control/status register
`timescale 1ns/100ps
`include "halt_dbg_params.svh"

module halting_debug_status_control #(
	parameter bit HALT_DEBUG_IMPL = 1'b1, // Halting debug present
	parameter bit WATCH_IMPL      = 1'b1  // Watchpoint unit present
) (
	// Clock and resets
	input  wire logic                    ref_clk,
	input  wire logic                    rst_b,
	input  wire logic                    warm_rst_b,
	// Register access
	input  wire halt_dbg_pkg::reg_req_t  req,
	output logic                         ack,
	output logic [31:0]                  rdata,
	output logic                         fault,
	// Core events and state
	input  wire halt_dbg_pkg::core_evt_t evt,
	// Controls to the core
	output logic                         halt_req,
	output logic                         step_en,
	output logic                         snap_en,
	output logic                         mask_nonsecure_irqs,
	output logic                         mask_secure_irqs,
	output logic                         restart_core
);

	////////////////////////////////////////////////////////////////////////
	// State
	halt_dbg_pkg::state_t s_q;             // Registered state
	halt_dbg_pkg::state_t s_d;             // Next state
	logic                 dbg_allowed;     // Debug enabled and permitted
	logic                 sde_now;         // Secure debug status as read
	logic [31:0]          halt_rd;         // Halting register read image
	logic                 key_ok;          // Write carries the key
	logic                 hit_evt;         // Event flag register selected
	logic                 hit_halt;        // Halting register selected
	logic                 alias_hit;       // Either alias selected
	logic                 clr_halt_req;    // Halt control being cleared
	logic                 set_halt_req;    // Halt control being set

	assign dbg_allowed = s_q.dbgen & evt.halt_allowed;
	// Status tracks the live condition while running, frozen in debug
	assign sde_now = s_q.in_debug ? s_q.sde_latch : evt.sec_halt_allowed;

	////////////////////////////////////////////////////////////////////////
	// Address decode
	always_comb begin
		alias_hit = (req.addr == `EVT_FLAG_ALIAS) | (req.addr == `HALT_REG_ALIAS);
		// Aliases answer only Secure software, never the debugger
		hit_evt = (req.addr == `EVT_FLAG_ADDR) |
			((req.addr == `EVT_FLAG_ALIAS) & req.secure & ~req.debugger);
		hit_halt = HALT_DEBUG_IMPL & ((req.addr == `HALT_REG_ADDR) |
			((req.addr == `HALT_REG_ALIAS) & req.secure & ~req.debugger));
		key_ok = req.wdata[31:16] == `WRITE_KEY;
	end

	////////////////////////////////////////////////////////////////////////
	// Read image: status high, control low, reserved zero
	always_comb begin
		halt_rd = 32'h0000_0000;
		halt_rd[`ST_RESTART_BIT] = s_q.restart_st;
		halt_rd[`ST_RESET_BIT]   = s_q.reset_st;
		halt_rd[`ST_RETIRE_BIT]  = s_q.retire_st;
		halt_rd[`ST_SDE_BIT]     = sde_now;
		// Lockup visible only to the remote debugger, while running
		halt_rd[`ST_LOCKUP_BIT]  = evt.locked_up & ~s_q.in_debug & req.debugger;
		halt_rd[`ST_SLEEP_BIT]   = evt.sleeping;
		halt_rd[`ST_HALT_BIT]    = s_q.in_debug;
		halt_rd[`ST_REGRDY_BIT]  = s_q.regrdy;
		halt_rd[`C_SNAP_BIT]     = s_q.snap;
		halt_rd[`C_MASK_BIT]     = s_q.mask;
		halt_rd[`C_STEP_BIT]     = s_q.step;
		halt_rd[`C_HALT_BIT]     = s_q.halt;
		halt_rd[`C_DBGEN_BIT]    = s_q.dbgen;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		s_d.fault = 1'b0;
		s_d.rdata = 32'h0000_0000;
		s_d.in_debug = evt.in_debug;
		clr_halt_req = 1'b0;
		set_halt_req = 1'b0;

		// Sticky event flags; set wins over a same-cycle clear
		if (req.valid & req.write & req.priv & req.word & hit_evt) begin
			s_d.evt_flags = s_q.evt_flags & ~req.wdata[4:0];
		end
		if (evt.ext_req) s_d.evt_flags[`EVT_EXT_BIT] = 1'b1;
		if (evt.vector_catch_flag & HALT_DEBUG_IMPL) s_d.evt_flags[`EVT_VECTOR_CATCH_FLAG_BIT] = 1'b1;
		if (evt.watch & WATCH_IMPL) s_d.evt_flags[`EVT_WATCH_BIT] = 1'b1;
		if (evt.breakpoint_flag) s_d.evt_flags[`EVT_BREAKPOINT_FLAG_BIT] = 1'b1;
		if (evt.halt_step) s_d.evt_flags[`EVT_HALT_BIT] = 1'b1;

		// Bus access answer
		if (req.valid) begin
			s_d.ack = 1'b1;
			// Unprivileged access faults; odd sizes are simply dropped
			if (~req.priv) begin
				s_d.fault = 1'b1;
			end else if (req.word & ~req.write) begin
				if (hit_evt) begin
					s_d.rdata = {27'h0000000, s_q.evt_flags};
				end else if (hit_halt) begin
					s_d.rdata = halt_rd;
					// Reading clears the read-sensitive stickies
					s_d.restart_st = 1'b0;
					s_d.reset_st = 1'b0;
					s_d.retire_st = 1'b0;
				end
			end else if (req.word & req.write & hit_halt & key_ok) begin
				if (req.debugger) s_d.dbgen = req.wdata[`C_DBGEN_BIT];
				s_d.halt = req.wdata[`C_HALT_BIT];
				s_d.step = req.wdata[`C_STEP_BIT];
				s_d.mask = req.wdata[`C_MASK_BIT];
				// Snap stall only takes writes with secure debug allowed
				if (sde_now) s_d.snap = req.wdata[`C_SNAP_BIT];
				clr_halt_req = s_q.halt & ~req.wdata[`C_HALT_BIT];
			end
		end
		if (alias_hit & ~hit_evt & ~hit_halt) s_d.rdata = 32'h0000_0000;

		// Restart from register write or external restart request
		clr_halt_req = clr_halt_req | (evt.restart_req & s_q.halt);
		set_halt_req = dbg_allowed & (evt.ext_req | evt.vector_catch_flag | evt.watch | evt.breakpoint_flag | evt.halt_step);
		if (clr_halt_req) begin
			s_d.halt = 1'b0;
			s_d.restart_st = 1'b1;
		end
		// A coincident set re-halts at once, restart still recorded
		if (set_halt_req) s_d.halt = 1'b1;

		if (evt.retire) s_d.retire_st = 1'b1;

		// Secure debug status captured at debug entry
		if (evt.in_debug & ~s_q.in_debug) begin
			s_d.sde_latch = evt.secure_state | evt.sec_halt_allowed;
		end

		// Core register transfer handshake
		if (evt.xfer_req) s_d.regrdy = 1'b0;
		if (evt.xfer_done) s_d.regrdy = 1'b1;

		// Warm reset: reset sticky set, halt cleared, optional catch
		if (~warm_rst_b) begin
			s_d.reset_st = 1'b1;
			s_d.halt = 1'b0;
			s_d.catch_on_reset_enable = s_q.catch_on_reset_enable;
			// Pended regardless of security state or secure debug
			if (dbg_allowed & s_q.catch_on_reset_enable & HALT_DEBUG_IMPL) begin
				s_d.evt_flags[`EVT_VECTOR_CATCH_FLAG_BIT] = 1'b1;
				s_d.halt = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register, cold reset synchronous
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.reset_st <= 1'b1;
			s_q.regrdy <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs; controls other than restart_core act as zero when debug is not allowed
	assign ack = s_q.ack;
	assign rdata = s_q.rdata;
	assign fault = s_q.fault;
	assign halt_req = s_q.halt & dbg_allowed & (sde_now | ~evt.secure_state);
	assign step_en = s_q.step & dbg_allowed & (sde_now | ~evt.secure_state);
	assign snap_en = s_q.snap & dbg_allowed;
	// Mask never reaches the non-maskable interrupt
	assign mask_nonsecure_irqs = s_q.mask & dbg_allowed;
	assign mask_secure_irqs = s_q.mask & dbg_allowed & sde_now;
	assign restart_core = ~s_q.halt & s_q.in_debug;

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_ext_flag;
		@(posedge ref_clk) disable iff (!rst_b) evt.ext_req |=> s_q.evt_flags[`EVT_EXT_BIT];
	endproperty
	a_ext_flag: assert property (p_ext_flag) else $error("external flag not set");

	property p_w1c;
		@(posedge ref_clk) disable iff (!rst_b)
			(req.valid & req.write & req.priv & req.word & hit_evt & req.wdata[1] & ~evt.breakpoint_flag)
			|=> !s_q.evt_flags[`EVT_BREAKPOINT_FLAG_BIT];
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear");

	property p_unpriv;
		@(posedge ref_clk) disable iff (!rst_b) (req.valid & ~req.priv) |=> fault & ack;
	endproperty
	a_unpriv: assert property (p_unpriv) else $error("unprivileged access not faulted");

	property p_nokey;
		@(posedge ref_clk) disable iff (!rst_b)
			(req.valid & req.write & ~key_ok & ~evt.retire) |=> $stable(s_q.dbgen) && $stable(s_q.mask);
	endproperty
	a_nokey: assert property (p_nokey) else $error("keyless write changed control");

	sequence s_halt_read;
		req.valid & ~req.write & req.priv & req.word & hit_halt & ~warm_rst_b == 1'b0;
	endsequence
	property p_read_clr;
		@(posedge ref_clk) disable iff (!rst_b) s_halt_read ##0 ~evt.retire |=> !s_q.retire_st;
	endproperty
	a_read_clr: assert property (p_read_clr) else $error("read did not clear retire");

	property p_warm;
		@(posedge ref_clk) disable iff (!rst_b) !warm_rst_b |=> s_q.reset_st;
	endproperty
	a_warm: assert property (p_warm) else $error("reset sticky not set");

	property p_regrdy;
		@(posedge ref_clk) disable iff (!rst_b) (evt.xfer_req & ~evt.xfer_done) |=> !s_q.regrdy;
	endproperty
	a_regrdy: assert property (p_regrdy) else $error("transfer ready not dropped");

	property p_mask_gate;
		@(posedge ref_clk) disable iff (!rst_b) !dbg_allowed |-> !mask_nonsecure_irqs && !step_en;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("control active while disallowed");

	property p_alias;
		@(posedge ref_clk) disable iff (!rst_b)
			(req.valid & ~req.write & req.debugger & (req.addr == `HALT_REG_ALIAS)) |=> rdata == 32'h0000_0000;
	endproperty
	a_alias: assert property (p_alias) else $error("alias visible to debugger");

	////////////////////////////////////////////////////////////////////////
	// Event flag, sticky status and control checks
	property p_vector_catch_flag_flag;
		@(posedge ref_clk) disable iff (!rst_b) (evt.vector_catch_flag & HALT_DEBUG_IMPL) |=> s_q.evt_flags[`EVT_VECTOR_CATCH_FLAG_BIT];
	endproperty
	a_vector_catch_flag_flag: assert property (p_vector_catch_flag_flag) else $error("vector catch flag not set");

	property p_watch_flag;
		@(posedge ref_clk) disable iff (!rst_b) (evt.watch & WATCH_IMPL) |=> s_q.evt_flags[`EVT_WATCH_BIT];
	endproperty
	a_watch_flag: assert property (p_watch_flag) else $error("watchpoint flag not set");

	property p_breakpoint_flag_flag;
		@(posedge ref_clk) disable iff (!rst_b) evt.breakpoint_flag |=> s_q.evt_flags[`EVT_BREAKPOINT_FLAG_BIT];
	endproperty
	a_breakpoint_flag_flag: assert property (p_breakpoint_flag_flag) else $error("breakpoint flag not set");

	property p_halt_flag;
		@(posedge ref_clk) disable iff (!rst_b) evt.halt_step |=> s_q.evt_flags[`EVT_HALT_BIT];
	endproperty
	a_halt_flag: assert property (p_halt_flag) else $error("halt or step flag not set");

	property p_restart;
		@(posedge ref_clk) disable iff (!rst_b) (evt.restart_req & s_q.halt) |=> s_q.restart_st;
	endproperty
	a_restart: assert property (p_restart) else $error("restart sticky not set");

	// Clear and set in one cycle: both steps must show afterwards
	sequence s_clear_req;
		evt.restart_req & s_q.halt;
	endsequence
	sequence s_set_req;
		set_halt_req & warm_rst_b;
	endsequence
	property p_coincide;
		@(posedge ref_clk) disable iff (!rst_b) s_clear_req ##0 s_set_req |=> s_q.halt && s_q.restart_st;
	endproperty
	a_coincide: assert property (p_coincide) else $error("coincident clear and set mishandled");

	property p_retire;
		@(posedge ref_clk) disable iff (!rst_b) evt.retire |=> s_q.retire_st;
	endproperty
	a_retire: assert property (p_retire) else $error("retire sticky not set");

	// Latch must not move while the core stays halted
	property p_sde_hold;
		@(posedge ref_clk) disable iff (!rst_b) (s_q.in_debug & evt.in_debug) |=> $stable(s_q.sde_latch);
	endproperty
	a_sde_hold: assert property (p_sde_hold) else $error("secure debug status moved in debug");

	property p_lockup_hide;
		@(posedge ref_clk) disable iff (!rst_b) s_q.in_debug |-> !halt_rd[`ST_LOCKUP_BIT];
	endproperty
	a_lockup_hide: assert property (p_lockup_hide) else $error("lockup shown in debug");

	property p_regrdy_done;
		@(posedge ref_clk) disable iff (!rst_b) evt.xfer_done |=> s_q.regrdy;
	endproperty
	a_regrdy_done: assert property (p_regrdy_done) else $error("transfer ready not raised");

	property p_snap_gate;
		@(posedge ref_clk) disable iff (!rst_b) (req.valid & ~sde_now) |=> $stable(s_q.snap);
	endproperty
	a_snap_gate: assert property (p_snap_gate) else $error("snap stall written without secure debug");

	// Software must never be able to open halting debug on its own
	property p_dbgen_sw;
		@(posedge ref_clk) disable iff (!rst_b) (req.valid & ~req.debugger) |=> $stable(s_q.dbgen);
	endproperty
	a_dbgen_sw: assert property (p_dbgen_sw) else $error("software changed debug enable");

	property p_set_halt;
		@(posedge ref_clk) disable iff (!rst_b) (set_halt_req & warm_rst_b) |=> s_q.halt;
	endproperty
	a_set_halt: assert property (p_set_halt) else $error("debug event did not set halt");

	property p_nonword;
		@(posedge ref_clk) disable iff (!rst_b) (req.valid & ~req.word) |=> ack && rdata == 32'h0000_0000;
	endproperty
	a_nonword: assert property (p_nonword) else $error("odd size access returned data");

	// Catch enable has no writer here yet; kept for the neighbouring register
	property p_warm_catch;
		@(posedge ref_clk) disable iff (!rst_b)
			(!warm_rst_b & dbg_allowed & s_q.catch_on_reset_enable & HALT_DEBUG_IMPL)
			|=> s_q.evt_flags[`EVT_VECTOR_CATCH_FLAG_BIT] && s_q.halt;
	endproperty
	a_warm_catch: assert property (p_warm_catch) else $error("reset catch not pended");

endmodule

// ---- testbench/debug_host_model.sv ----
// Debugger and software access model on the register request port
`timescale 1ns/100ps
`include "halt_dbg_params.svh"

module debug_host_model (
	// Clock
	input  wire logic              ref_clk,
	// Request and answer
	output halt_dbg_pkg::reg_req_t req,
	input  wire logic              ack,
	input  wire logic [31:0]       rdata,
	input  wire logic              fault
);
	// Idle until the first access
	initial req = '0;

	////////////////////////////////////////////////////////////////////////
	// One access: valid for one edge, answer taken in the ack cycle
	// k packs write, word, priv, secure, debugger
	task automatic xfer(input logic [4:0] k, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic f, output bit tmo);
		@(posedge ref_clk);
		#1 req = {1'b1, k[4], a, d, k[3:0]};
		@(posedge ref_clk);
		#1 req.valid = 1'b0;
		// Released lines flip so a stale address never passes for a live one
		req.addr = ~a;
		req.wdata = ~d;
		tmo = 1'b1;
		// Ack stands one cycle; a short bound catches a dead port
		for (int i = 0; i < 4 && tmo; i++) begin
			if (ack === 1'b1) begin
				r = rdata;
				f = fault;
				tmo = 1'b0;
			end else begin
				@(posedge ref_clk);
				#1;
			end
		end
	endtask
endmodule

// ---- testbench/tb_halting_debug_status_control.sv ----
// Self-checking bench for the halting debug flags and control register
`timescale 1ns/100ps
`include "halt_dbg_params.svh"

module tb_halting_debug_status_control;
	logic                      ref_clk = 1'b0;  // 25 MHz clock
	logic                      rst_b = 1'b0;    // Cold reset
	logic                      warm_rst_b = 1'b1;
	halt_dbg_pkg::reg_req_t    req;
	halt_dbg_pkg::core_evt_t   ev = 15'h000c;   // Secure halting and halting allowed
	logic                      ack, fault, hq, st, sn, mn, ms, rc;
	logic [31:0]               rdata;
	int                        fails = 0, checks_done = 0, seed = 77343;
	bit                        rs, rt, re, rdy;  // Model stickies and ready
	bit [4:0]                  fl;               // Model event flags
	bit [5:0]                  ct;               // Model control bits
	localparam logic [4:0]     DR = 5'b01101, SR = 5'b01100, DW = 5'b11101, SW = 5'b11100;

	always #20 ref_clk = ~ref_clk;

	halting_debug_status_control DUT (.ref_clk(ref_clk), .rst_b(rst_b), .warm_rst_b(warm_rst_b),
		.req(req), .ack(ack), .rdata(rdata), .fault(fault), .evt(ev), .halt_req(hq), .step_en(st),
		.snap_en(sn), .mask_nonsecure_irqs(mn), .mask_secure_irqs(ms), .restart_core(rc));
	debug_host_model hm (.ref_clk(ref_clk), .req(req), .ack(ack), .rdata(rdata), .fault(fault));

	////////////////////////////////////////////////////////////////////////
	// Counts, verdict and comparison
	task automatic print_verdict();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Access with expected data and fault; a timeout ends the run
	task automatic ck(input logic [4:0] k, input logic [31:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic ef);
		logic [31:0] r;
		logic        f;
		bit          t;
		hm.xfer(k, a, d, r, f, t);
		if (t) begin
			fails++;
			print_verdict();
		end
		chk(r, e);
		chk({31'h0, f}, {31'h0, ef});
	endtask
	// Halting register read; stickies clear on read
	task automatic rdh(input bit dbg);
		ck(dbg ? DR : SR, `HALT_REG_ADDR, 0, {5'h00, rs, rt, re, 3'h0, ev.sec_halt_allowed,
			dbg & ev.locked_up & ~ev.in_debug, ev.sleeping, ev.in_debug, rdy, 10'h000, ct}, 0);
		{rs, rt, re} = 3'b000;
	endtask
	// Halting register write into the model
	task automatic wrh(input logic [4:0] k, input logic [31:0] d);
		ck(k, `HALT_REG_ADDR, d, 0, 0);
		if (d[31:16] == `WRITE_KEY) begin
			if (k[0]) ct[0] = d[0];
			ct[3:1] = d[3:1];
			if (ev.sec_halt_allowed) ct[5] = d[5];
		end
	endtask
	// Strobes held for one cycle
	task automatic pulse(input logic [14:0] m);
		@(posedge ref_clk);
		#1 ev = ev | m;
		@(posedge ref_clk);
		#1 ev = ev & ~m;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] r;
		repeat (5) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		{rt, rdy} = 2'b11;
		rdh(1);
		rdh(1);
		// Random writes lacking the key leave everything alone
		repeat (3) begin
			r = $random(seed);
			wrh(DW, {r[31:16] ^ {15'h0, r[31:16] == `WRITE_KEY}, r[15:0]});
			rdh(1);
		end
		wrh(SW, 32'ha05f0001);
		ev.locked_up = 1'b1;
		rdh(0);
		rdh(1);
		ev.locked_up = 1'b0;
		ev.sec_halt_allowed = 1'b0;
		wrh(DW, 32'ha05f0023);
		chk({27'h0, hq, st, sn, mn, ms}, 32'h10);
		ev.sec_halt_allowed = 1'b1;
		ev.in_debug = 1'b1;
		wrh(DW, 32'ha05f000b);
		chk({27'h0, hq, st, sn, mn, ms}, 32'h13);
		rdh(1);
		ev.halt_allowed = 1'b0;
		#1 chk({27'h0, hq, st, sn, mn, ms}, 32'h00);
		ev.halt_allowed = 1'b1;
		pulse(15'h0002);
		rdy = 1'b0;
		rdh(1);
		pulse(15'h0001);
		rdy = 1'b1;
		rdh(1);
		// Each event source sets its own sticky flag
		for (int i = 0; i < 5; i++) begin
			pulse(15'h4000 >> i);
			fl[4 - i] = 1'b1;
			ck(DR, `EVT_FLAG_ADDR, 0, {27'h0, fl}, 0);
		end
		pulse(15'h0100);
		re = 1'b1;
		rdh(1);
		pulse(15'h0200);
		{rs, ct[1]} = 2'b10;
		chk({31'h0, rc}, 32'h1);
		rdh(1);
		// Re-halt first, then restart with a coincident event: halt stays set, restart recorded
		pulse(15'h4000);
		pulse(15'h4200);
		{rs, ct[1]} = 2'b11;
		rdh(1);
		ck(5'b01000, `EVT_FLAG_ADDR, 0, 0, 1);
		ck(5'b00101, `EVT_FLAG_ADDR, 0, 0, 0);
		ck(5'b10101, `EVT_FLAG_ADDR, 32'h1f, 0, 0);
		ck(DR, `EVT_FLAG_ALIAS, 0, 0, 0);
		ck(5'b01110, `EVT_FLAG_ALIAS, 0, {27'h0, fl}, 0);
		ck(DR, `HALT_REG_ALIAS, 0, 0, 0);
		ck(DR, 32'he000ed34, 0, 0, 0);
		ck(DW, `EVT_FLAG_ADDR, 32'hffff_ff15, 0, 0);
		fl = fl & 5'h0a;
		ck(DR, `EVT_FLAG_ADDR, 0, {27'h0, fl}, 0);
		// Warm reset with reset catch off: no catch, halt dropped
		ev.in_debug = 1'b0;
		@(posedge ref_clk);
		#1 warm_rst_b = 1'b0;
		@(posedge ref_clk);
		#1 warm_rst_b = 1'b1;
		{rt, ct[1]} = 2'b10;
		rdh(1);
		ck(DR, `EVT_FLAG_ADDR, 0, {27'h0, fl}, 0);
		@(posedge ref_clk);
		#1 rst_b = 1'b0;
		@(posedge ref_clk);
		#1 rst_b = 1'b1;
		ck(DR, `EVT_FLAG_ADDR, 0, 0, 0);
		print_verdict();
	end
endmodule
